// *** logic/obus_consts.svh ***
`ifndef OBUS_CONSTS_SVH
`define OBUS_CONSTS_SVH

// Transaction kinds, one bit each in every request or grant vector
`define KIND_MEM_RET 0
`define KIND_MEM_RD 1
`define KIND_MEM_WR 2
`define KIND_IO_RD 3
`define KIND_IO_RET 4
`define KIND_NUM 5

// Bus states taken by each kind
`define LEN_MEM_RET 3'h4
`define LEN_MEM_RD 3'h1
`define LEN_MEM_WR 3'h5
`define LEN_IO_RD 3'h1
`define LEN_IO_RET 3'h1

// Kinds whose first state is an address state
`define ADDR_FIRST_MASK 5'h0E

// Pending-transaction queue in the source end
`define QDEPTH 8
`define QDEPTH_CNT 4'h8
`define QCNT_W 4
`define QPTR_W 3

`endif

// *** logic/obus_pkg.sv ***
package obus_pkg;
   `include "obus_consts.svh"

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_GRANT = 2'b01,
      ARB_BUSY = 2'b10
   } arb_state_type;

   // Number of bus states for a one-hot kind vector
   function automatic logic [2:0] xfer_len(input logic [4:0] kind_hot);
      logic [2:0] len;
      len = 3'h0;
      if (kind_hot[`KIND_MEM_RET]) len = `LEN_MEM_RET;
      if (kind_hot[`KIND_MEM_RD]) len = `LEN_MEM_RD;
      if (kind_hot[`KIND_MEM_WR]) len = `LEN_MEM_WR;
      if (kind_hot[`KIND_IO_RD]) len = `LEN_IO_RD;
      if (kind_hot[`KIND_IO_RET]) len = `LEN_IO_RET;
      return len;
   endfunction : xfer_len
endpackage : obus_pkg

// *** logic/obus_link_if.sv ***
interface obus_link_if;
   logic memory_return_request;
   logic memory_return_grant;
   logic shared_return;
   logic zero_len_return_strobe;
   logic [3:0] zero_len_return_tag;
   logic mem_read_request;
   logic mem_read_grant;
   logic zero_len_hint;
   logic mem_write_request;
   logic mem_write_grant;
   logic io_read_request;
   logic io_read_grant;
   logic io_space_return_request;
   logic io_space_return_grant;

   modport arbiter_mp (
      input memory_return_request, shared_return, zero_len_return_strobe,
      input zero_len_return_tag, mem_read_request, zero_len_hint,
      input mem_write_request, io_read_request, io_space_return_request,
      output memory_return_grant, mem_read_grant, mem_write_grant,
      output io_read_grant, io_space_return_grant
   );

   modport source_mp (
      output memory_return_request, shared_return, zero_len_return_strobe,
      output zero_len_return_tag, mem_read_request, zero_len_hint,
      output mem_write_request, io_read_request, io_space_return_request,
      input memory_return_grant, mem_read_grant, mem_write_grant,
      input io_read_grant, io_space_return_grant
   );
endinterface : obus_link_if

// *** logic/obus_arbiter.sv ***
`include "obus_consts.svh"

module obus_arbiter import obus_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link to the request sources
   obus_link_if.arbiter_mp link,
   // Bus activity seen by the output-bus owner, one cycle late
   output logic bus_busy,
   output logic [4:0] xfer_start,
   output logic start_shared,
   output logic start_hint,
   output logic zl_valid,
   output logic [3:0] zl_tag
);

   arb_state_type state_q, state_d;
   logic [4:0] gnt_q, gnt_d;
   logic [2:0] cnt_q, cnt_d;

   wire [4:0] req_w = {link.io_space_return_request, link.io_read_request,
                       link.mem_write_request, link.mem_read_request,
                       link.memory_return_request};
   // Fixed order: lowest kind index wins; fairness is left to the sources
   wire [4:0] pick_w = req_w & (~req_w + 5'h01);
   wire [4:0] hit_w = gnt_q & req_w;
   wire start_w = |hit_w;
   wire [2:0] len_w = xfer_len(hit_w);
   wire busy_d = start_w | (state_q == ARB_BUSY);

   assign link.memory_return_grant = gnt_q[`KIND_MEM_RET];
   assign link.mem_read_grant = gnt_q[`KIND_MEM_RD];
   assign link.mem_write_grant = gnt_q[`KIND_MEM_WR];
   assign link.io_read_grant = gnt_q[`KIND_IO_RD];
   assign link.io_space_return_grant = gnt_q[`KIND_IO_RET];

   always_comb begin
      state_d = state_q;
      gnt_d = gnt_q;
      cnt_d = cnt_q;
      case (state_q)
         ARB_IDLE: begin
            if (|req_w) begin
               gnt_d = pick_w;
               state_d = ARB_GRANT;
            end
         end
         ARB_GRANT: begin
            gnt_d = 5'h00;
            if (start_w) begin
               // First state is the start cycle itself; count the rest
               cnt_d = len_w - 3'h1;
               state_d = (len_w == 3'h1) ? ARB_IDLE : ARB_BUSY;
            end else begin
               state_d = ARB_IDLE;
            end
         end
         ARB_BUSY: begin
            // No grant until the last address or data state is out
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1) state_d = ARB_IDLE;
         end
         default: begin
            state_d = ARB_IDLE;
            gnt_d = 5'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ARB_IDLE;
         gnt_q <= 5'h00;
         cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         gnt_q <= gnt_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_busy <= 1'b0;
         xfer_start <= 5'h00;
         start_shared <= 1'b0;
         start_hint <= 1'b0;
      end else begin
         bus_busy <= busy_d;
         xfer_start <= hit_w;
         start_shared <= hit_w[`KIND_MEM_RET] & link.shared_return;
         start_hint <= hit_w[`KIND_MEM_RD] & link.zero_len_hint;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zl_valid <= 1'b0;
         zl_tag <= 4'h0;
      end else begin
         zl_valid <= link.zero_len_return_strobe;
         if (link.zero_len_return_strobe) zl_tag <= link.zero_len_return_tag;
      end
   end

endmodule : obus_arbiter

// *** logic/obus_source.sv ***
// Contract
// - memory return: four data states from start
// - zero-length return strobe carries 4-bit tag
// - shared flag accompanies memory return request
// - hold memory read request until granted, drained
// - memory read: one address state from start
// - zero-length hint may accompany memory read
// - hold memory write request until granted, drained
// - memory write: one address, four data states
// - hold I/O read request until granted, drained
// - I/O read: one address state from start
// - hold I/O return request until granted, drained
// - I/O return: one eight-byte data state
// - hold memory return request until granted, drained
`include "obus_consts.svh"

module obus_source import obus_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link to the arbiter
   obus_link_if.source_mp link,
   // Queue pushes, one bit per kind
   input wire logic [4:0] push,
   input wire logic [4:0] push_attr,
   // Zero-length return notice
   input wire logic zl_push,
   input wire logic [3:0] zl_tag,
   // Queue status
   output wire logic [4:0] queue_full,
   output wire logic [4:0] started,
   // Own bus states, one cycle late
   output logic phase_addr,
   output logic phase_data,
   output logic [4:0] phase_kind
);

   wire [4:0] gnt_w = {link.io_space_return_grant, link.io_read_grant,
                       link.mem_write_grant, link.mem_read_grant,
                       link.memory_return_grant};
   wire [4:0] req_w;
   wire [4:0] head_w;
   wire [4:0] pop_w;

   // One queue per kind; a pop is the start cycle, request and grant both high
   for (genvar k = 0; k < `KIND_NUM; k++) begin : g_kind
      kind_queue kind_queue_inst (
         .clk(clk),
         .arst_n(arst_n),
         .push(push[k]),
         .push_attr(push_attr[k]),
         .gnt(gnt_w[k]),
         .req(req_w[k]),
         .head_attr(head_w[k]),
         .full(queue_full[k]),
         .started(started[k])
      );
   end

   assign pop_w = req_w & gnt_w;

   assign link.memory_return_request = req_w[`KIND_MEM_RET];
   assign link.mem_read_request = req_w[`KIND_MEM_RD];
   assign link.mem_write_request = req_w[`KIND_MEM_WR];
   assign link.io_read_request = req_w[`KIND_IO_RD];
   assign link.io_space_return_request = req_w[`KIND_IO_RET];

   // Only the head entry's attribute is shown, so it never lags its request
   assign link.shared_return = head_w[`KIND_MEM_RET];
   assign link.zero_len_hint = head_w[`KIND_MEM_RD];

   logic zl_strobe_q;
   logic [3:0] zl_tag_q;

   // Strobe and tag leave together from the same edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zl_strobe_q <= 1'b0;
         zl_tag_q <= 4'h0;
      end else begin
         zl_strobe_q <= zl_push;
         if (zl_push) zl_tag_q <= zl_tag;
      end
   end

   assign link.zero_len_return_strobe = zl_strobe_q;
   assign link.zero_len_return_tag = zl_tag_q;

   // Bus-state tracker for the transaction this end owns
   logic [2:0] rem_q;
   logic [2:0] rem_d;
   logic [4:0] kind_q;
   logic [4:0] kind_d;

   wire pop_any = |pop_w;
   wire in_xfer = (rem_q != 3'h0);
   wire [2:0] pop_len = xfer_len(pop_w);
   wire addr_d = |(pop_w & `ADDR_FIRST_MASK);
   wire data_d = (pop_any & ~addr_d) | in_xfer;

   always_comb begin
      rem_d = rem_q;
      kind_d = kind_q;
      if (pop_any) begin
         // Back-to-back states with no idle cycle between them
         rem_d = pop_len - 3'h1;
         kind_d = pop_w;
      end else if (in_xfer) begin
         rem_d = rem_q - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rem_q <= 3'h0;
         kind_q <= 5'h00;
      end else begin
         rem_q <= rem_d;
         kind_q <= kind_d;
      end
   end

   // Delayed a cycle so these outputs come from flip-flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_addr <= 1'b0;
         phase_data <= 1'b0;
         phase_kind <= 5'h00;
      end else begin
         phase_addr <= addr_d;
         phase_data <= data_d;
         phase_kind <= (pop_any | in_xfer) ? kind_d : 5'h00;
      end
   end

endmodule : obus_source

module kind_queue import obus_pkg::*; #(
   parameter int DEPTH = `QDEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Producer side
   input wire logic push,
   input wire logic push_attr,
   // Link side
   input wire logic gnt,
   output logic req,
   output logic head_attr,
   // Status
   output logic full,
   output logic started
);

   logic [`QCNT_W-1:0] cnt_q;
   logic [`QCNT_W-1:0] cnt_d;
   logic [`QCNT_W-1:0] remain_w;
   logic [`QPTR_W-1:0] wr_q;
   logic [`QPTR_W-1:0] rd_q;
   logic [`QPTR_W-1:0] rd_d;
   logic [DEPTH-1:0] attr_q;
   logic head_d;
   logic push_ok;
   logic pop;

   // A push into a full queue is dropped; the producer must watch full
   assign push_ok = push & (cnt_q != `QDEPTH_CNT);
   assign pop = req & gnt;
   assign remain_w = cnt_q - {3'h0, pop};
   assign cnt_d = remain_w + {3'h0, push_ok};
   assign rd_d = rd_q + {2'h0, pop};

   // Head flag follows the request it belongs to
   always_comb begin
      if (cnt_d == 4'h0) begin
         head_d = 1'b0;
      end else if (remain_w == 4'h0) begin
         head_d = push_attr;
      end else begin
         head_d = attr_q[rd_d];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         rd_q <= 3'h0;
         req <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         // Held through the grant until nothing of this kind is left
         req <= (cnt_d != 4'h0);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= 3'h0;
         attr_q <= '0;
      end else if (push_ok) begin
         wr_q <= wr_q + 3'h1;
         attr_q[wr_q] <= push_attr;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         head_attr <= 1'b0;
         full <= 1'b0;
         started <= 1'b0;
      end else begin
         head_attr <= head_d;
         full <= (cnt_d == `QDEPTH_CNT);
         started <= pop;
      end
   end

endmodule : kind_queue

// *** tb/obus_link_sva.sv ***
module obus_link_sva (
   // Clock and reset
   input logic clk,
   input logic arst_n,
   // Requests
   input logic memory_return_request,
   input logic mem_read_request,
   input logic mem_write_request,
   input logic io_read_request,
   input logic io_space_return_request,
   // Grants
   input logic memory_return_grant,
   input logic mem_read_grant,
   input logic mem_write_grant,
   input logic io_read_grant,
   input logic io_space_return_grant,
   // Zero-length notice
   input logic zero_len_return_strobe,
   input logic [3:0] zero_len_return_tag
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [4:0] gnts = {io_space_return_grant, io_read_grant, mem_write_grant, mem_read_grant,
      memory_return_grant};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_quiet;
      gnts == 5'h00;
   endsequence
   sequence s_ret_start;
      memory_return_request && memory_return_grant;
   endsequence
   sequence s_wr_start;
      mem_write_request && mem_write_grant;
   endsequence
   // A waiting request may not drop before its grant
   property p_hold(req, gnt);
      req && !gnt |=> req;
   endproperty
   property p_pulse(req, gnt);
      req && gnt |=> !gnt;
   endproperty
   AST_ONE_GRANT: assert property ($onehot0(gnts))
      else $error("two grants at once");
   AST_RET_SPAN: assert property (s_ret_start |=> s_quiet [*3])
      else $error("grant inside memory return");
   AST_WR_SPAN: assert property (s_wr_start |=> s_quiet [*4])
      else $error("grant inside memory write");
   AST_RD_PULSE: assert property (p_pulse(mem_read_request, mem_read_grant))
      else $error("memory read grant too long");
   AST_IORD_PULSE: assert property (p_pulse(io_read_request, io_read_grant))
      else $error("io read grant too long");
   AST_IORET_PULSE: assert property (p_pulse(io_space_return_request, io_space_return_grant))
      else $error("io return grant too long");
   AST_RET_HOLD: assert property (p_hold(memory_return_request, memory_return_grant))
      else $error("memory return request dropped");
   AST_RD_HOLD: assert property (p_hold(mem_read_request, mem_read_grant))
      else $error("memory read request dropped");
   AST_WR_HOLD: assert property (p_hold(mem_write_request, mem_write_grant))
      else $error("memory write request dropped");
   AST_IORD_HOLD: assert property (p_hold(io_read_request, io_read_grant))
      else $error("io read request dropped");
   AST_IORET_HOLD: assert property (p_hold(io_space_return_request, io_space_return_grant))
      else $error("io return request dropped");
   AST_TAG_KEEP: assert property ($changed(zero_len_return_tag) |-> zero_len_return_strobe)
      else $error("tag moved without strobe");
endmodule : obus_link_sva

// *** tb/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] push = 5'h00;
   logic [4:0] push_attr = 5'h00;
   logic zl_push = 1'b0;
   logic [3:0] zl_tag_in = 4'h0;
   logic [4:0] queue_full, started, phase_kind, xfer_start;
   logic phase_addr, phase_data, bus_busy, start_shared, start_hint, zl_valid;
   logic [3:0] zl_tag;
   logic sh_q[$], hint_q[$];
   logic [3:0] tag_q[$];
   int n_errors = 0;
   int comparisons = 0;
   int n_addr[5], n_data[5], n_start[5], n_xfer[5], n_busy;
   logic [4:0] full_seen = 5'h00;
   int exp_addr[5] = '{0, 1, 1, 1, 0};
   int exp_data[5] = '{4, 0, 4, 0, 1};
   obus_link_if link();
   wire [4:0] link_reqs = {link.io_space_return_request, link.io_read_request,
      link.mem_write_request, link.mem_read_request, link.memory_return_request};
   always #5 clk = ~clk;
   obus_arbiter obus_arbiter_inst (.clk(clk), .arst_n(arst_n), .link(link.arbiter_mp),
      .bus_busy(bus_busy), .xfer_start(xfer_start), .start_shared(start_shared),
      .start_hint(start_hint), .zl_valid(zl_valid), .zl_tag(zl_tag));
   obus_source obus_source_inst (.clk(clk), .arst_n(arst_n), .link(link.source_mp),
      .push(push), .push_attr(push_attr), .zl_push(zl_push), .zl_tag(zl_tag_in),
      .queue_full(queue_full), .started(started), .phase_addr(phase_addr),
      .phase_data(phase_data), .phase_kind(phase_kind));
   obus_link_sva obus_link_sva_inst (.clk(clk), .arst_n(arst_n),
      .memory_return_request(link.memory_return_request),
      .mem_read_request(link.mem_read_request), .mem_write_request(link.mem_write_request),
      .io_read_request(link.io_read_request),
      .io_space_return_request(link.io_space_return_request),
      .memory_return_grant(link.memory_return_grant), .mem_read_grant(link.mem_read_grant),
      .mem_write_grant(link.mem_write_grant), .io_read_grant(link.io_read_grant),
      .io_space_return_grant(link.io_space_return_grant),
      .zero_len_return_strobe(link.zero_len_return_strobe),
      .zero_len_return_tag(link.zero_len_return_tag));
   // Status outputs lag one cycle, so every state is counted once here
   always @(posedge clk) begin
      if (arst_n) begin
         for (int k = 0; k < 5; k++) begin
            if (phase_kind[k]) begin
               n_addr[k] += phase_addr;
               n_data[k] += phase_data;
            end
            n_start[k] += started[k];
            n_xfer[k] += xfer_start[k];
         end
         n_busy += bus_busy;
         full_seen |= queue_full;
         if (zl_valid) tag_q.push_back(zl_tag);
         if (xfer_start[0]) sh_q.push_back(start_shared);
         if (xfer_start[1]) hint_q.push_back(start_hint);
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic clear();
      n_addr = '{5{0}};
      n_data = '{5{0}};
      n_start = '{5{0}};
      n_xfer = '{5{0}};
      n_busy = 0;
      full_seen = 5'h00;
      sh_q.delete();
      hint_q.delete();
      tag_q.delete();
   endtask : clear
   task automatic push_kinds(input logic [4:0] kinds, input logic [4:0] attr);
      @(posedge clk);
      push <= kinds;
      push_attr <= attr;
   endtask : push_kinds
   task automatic settle();
      int i;
      @(posedge clk);
      push <= 5'h00;
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (!bus_busy && link_reqs == 5'h00 && phase_kind == 5'h00) break;
      end
      check(16'(i < 300), 16'h0001);
   endtask : settle
   task automatic test_each_kind();
      for (int k = 0; k < 5; k++) begin
         clear();
         push_kinds(5'(1 << k), 5'h00);
         settle();
         check(16'(n_start[k]), 16'h0001);
         check(16'(n_xfer[k]), 16'h0001);
         check(16'(n_addr[k]), 16'(exp_addr[k]));
         check(16'(n_data[k]), 16'(exp_data[k]));
         check(16'(n_busy), 16'(exp_addr[k] + exp_data[k]));
      end
      $display("test_each_kind done");
   endtask : test_each_kind
   task automatic test_attrs();
      clear();
      push_kinds(5'h03, 5'h03);
      push_kinds(5'h03, 5'h00);
      settle();
      check(16'(n_start[0] + n_start[1]), 16'h0004);
      check({14'h0, sh_q[0], sh_q[1]}, 16'h0002);
      check({14'h0, hint_q[0], hint_q[1]}, 16'h0002);
      check(16'(n_busy), 16'h000a);
      $display("test_attrs done");
   endtask : test_attrs
   task automatic test_burst();
      clear();
      push_kinds(5'h0c, 5'h00);
      push_kinds(5'h04, 5'h00);
      push_kinds(5'h04, 5'h00);
      settle();
      check(16'(n_start[2]), 16'h0003);
      check(16'(n_data[2]), 16'h000c);
      check(16'(n_start[3]), 16'h0001);
      check(16'(n_busy), 16'h0010);
      $display("test_burst done");
   endtask : test_burst
   task automatic test_full();
      clear();
      repeat (11) push_kinds(5'h04, 5'h00);
      settle();
      check({11'h000, full_seen}, 16'h0004);
      check({11'h000, queue_full}, 16'h0000);
      check(16'(n_start[2]), 16'h000a);
      check(16'(n_data[2]), 16'h0028);
      check(16'(n_busy), 16'h0032);
      $display("test_full done");
   endtask : test_full
   task automatic test_zl();
      clear();
      @(posedge clk);
      zl_push <= 1'b1;
      zl_tag_in <= 4'h5;
      @(posedge clk);
      zl_tag_in <= 4'hf;
      @(posedge clk);
      zl_push <= 1'b0;
      zl_tag_in <= 4'h0;
      repeat (4) @(posedge clk);
      check(16'(tag_q.size()), 16'h0002);
      check({8'h00, tag_q[0], tag_q[1]}, 16'h005f);
      check({12'h000, zl_tag}, 16'h000f);
      $display("test_zl done");
   endtask : test_zl
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   // About 150 cycles of traffic; the limit leaves wide room
   initial begin
      #50000;
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      test_each_kind();
      test_attrs();
      test_burst();
      test_full();
      test_zl();
      print_verdict();
   end
endmodule : testbench
